// [rtl/dac_cal_regs.vh]
// Purpose: constants for the calibration and configuration register block
// Assumes: 24-bit serial frames, 18-bit data words
// Notes: included by the design files only
`ifndef DAC_CAL_REGS_VH
`define DAC_CAL_REGS_VH
// ==========================================================
// command select codes
`define CMD_NOP 4'h0
`define CMD_INPUT_WR 4'h1
`define CMD_OFFSET_WR 4'h2
`define CMD_GAIN_WR 4'h3
`define CMD_CONFIG_WR 4'h4
`define CMD_INPUT_RD 4'h9
`define CMD_OFFSET_RD 4'ha
`define CMD_GAIN_RD 4'hb
`define CMD_CONFIG_RD 4'hc
// ==========================================================
// frame layout
`define FRAME_BITS 5'h18
`define DATA_W 18
// ==========================================================
// configuration field positions
`define CFG_PD_BIT 17
`define CFG_HOLD_DIS_BIT 16
`define CFG_RST_N_BIT 15
`define CFG_BUSY_DIS_BIT 14
`define CFG_DOUT_ON_BIT 13
`define CFG_BUSY_STAT_BIT 12
`define CFG_REV_LSB 2
// ==========================================================
// reset values
`define OFFSET_RST 18'h00000
`define GAIN_RST 18'h3ffff
`define INPUT_RST 18'h00000
`define CFG_RST 5'h04
// ==========================================================
// arithmetic limits
`define CODE_MAX 18'h3ffff
`define CODE_MIN 18'h00000
`endif

// [rtl/dac_calibration_config_regs.v]
// Purpose: serially written calibration and configuration registers
// Assumes: host frames of 24 clocks, data sampled on rising serial clock
// Notes: serial pins are oversampled by core_clk after two flip-flops
`include "dac_cal_regs.vh"
module dac_calibration_config_regs #(
  parameter W = `DATA_W,
  parameter [3:0] REV_ID = 4'h1 // arbitrary revision value
) (
  input wire core_clk,
  input wire rst,
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_din,
  output reg spi_dout_r,
  output wire spi_dout_oe,
  input wire busy_in,
  output wire busy_out,
  output wire busy_oe,
  input wire power_down_pin,
  output wire out_to_ground,
  output reg [W-1:0] dac_code_r,
  output reg dac_update_r
);
  // ==========================================================
  // input synchronisers
  reg [1:0] sclk_s_r;
  reg [1:0] cs_s_r;
  reg [1:0] din_s_r;
  reg [1:0] busy_s_r;
  reg [1:0] pd_s_r;
  reg sclk_d_r;
  reg cs_d_r;
  // two flops per external input
  always @(posedge core_clk) begin
    if (rst) begin
      sclk_s_r <= 2'h0;
      cs_s_r <= 2'h3;
      din_s_r <= 2'h0;
      busy_s_r <= 2'h3;
      pd_s_r <= 2'h0;
    end else begin
      sclk_s_r <= {sclk_s_r[0], spi_sclk};
      cs_s_r <= {cs_s_r[0], spi_cs_n};
      din_s_r <= {din_s_r[0], spi_din};
      busy_s_r <= {busy_s_r[0], busy_in};
      pd_s_r <= {pd_s_r[0], power_down_pin};
    end
  end
  wire sclk_q = sclk_s_r[1];
  wire cs_q = cs_s_r[1];
  wire din_q = din_s_r[1];
  // edge detect on synchronised copies
  always @(posedge core_clk) begin
    if (rst) begin
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_q;
      cs_d_r <= cs_q;
    end
  end
  wire sclk_rise = sclk_q & ~sclk_d_r & ~cs_q;
  wire sclk_fall = ~sclk_q & sclk_d_r & ~cs_q;
  wire cs_fall = ~cs_q & cs_d_r;
  wire cs_rise = cs_q & ~cs_d_r;
  // ==========================================================
  // internal reset: pin reset or software reset
  reg soft_rst_r;
  wire irst = rst | soft_rst_r;
  // ==========================================================
  // serial shift and bit counter
  reg [23:0] rx_r;
  reg [23:0] tx_r;
  reg [4:0] bit_cnt_r;
  reg [23:0] tx_load_r;
  reg tx_load_v_r;
  // msb first capture, 24 bits per frame
  always @(posedge core_clk) begin
    if (irst) begin
      rx_r <= 24'h000000;
      bit_cnt_r <= 5'h00;
    end else if (cs_fall) begin
      bit_cnt_r <= 5'h00;
    end else if (sclk_rise) begin
      rx_r <= {rx_r[22:0], din_q};
      if (bit_cnt_r != 5'h1f)
        bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end
  wire frame_ok = (bit_cnt_r == `FRAME_BITS);
  wire [3:0] cmd = rx_r[23:20];
  wire [W-1:0] wdata = rx_r[19:2];
  wire frame_end = cs_rise & frame_ok;
  // ==========================================================
  // register file
  reg [W-1:0] offset_r;
  reg [W-1:0] gain_r;
  reg [W-1:0] input_r;
  reg soft_power_down_r;
  reg out_hold_disable_r;
  reg soft_reset_n_r;
  reg busy_in_disable_r;
  reg dout_on_r;
  reg calc_req_r;
  // writes take effect at the end of a complete frame
  always @(posedge core_clk) begin
    if (irst) begin
      offset_r <= `OFFSET_RST;
      gain_r <= `GAIN_RST;
      input_r <= `INPUT_RST;
      {soft_power_down_r, out_hold_disable_r, soft_reset_n_r,
        busy_in_disable_r, dout_on_r} <= `CFG_RST;
      calc_req_r <= 1'b0;
    end else begin
      calc_req_r <= 1'b0;
      if (frame_end) begin
        if (cmd == `CMD_INPUT_WR) begin
          input_r <= wdata;
          calc_req_r <= 1'b1;
        end else if (cmd == `CMD_OFFSET_WR) begin
          offset_r <= wdata;
          calc_req_r <= 1'b1;
        end else if (cmd == `CMD_GAIN_WR) begin
          gain_r <= wdata;
          calc_req_r <= 1'b1;
        end else if (cmd == `CMD_CONFIG_WR) begin
          // only the top five bits are used
          soft_power_down_r <= wdata[`CFG_PD_BIT];
          out_hold_disable_r <= wdata[`CFG_HOLD_DIS_BIT];
          soft_reset_n_r <= wdata[`CFG_RST_N_BIT];
          busy_in_disable_r <= wdata[`CFG_BUSY_DIS_BIT];
          dout_on_r <= wdata[`CFG_DOUT_ON_BIT];
        end
      end
    end
  end
  // software reset pulse from a cleared reset bit
  always @(posedge core_clk) begin
    if (rst)
      soft_rst_r <= 1'b0;
    else
      soft_rst_r <= ~soft_rst_r & ~soft_reset_n_r;
  end
  // ==========================================================
  // output calculation and deferred update
  reg [1:0] upd_state_r;
  reg [1:0] upd_state_nxt;
  localparam [1:0] UPD_IDLE = 2'b00;
  localparam [1:0] UPD_CALC = 2'b01;
  localparam [1:0] UPD_WAIT = 2'b10;
  reg pending_r;
  wire [W-1:0] calc_result;
  wire calc_done;
  wire calc_start = (upd_state_r == UPD_IDLE) & (pending_r | calc_req_r);
  wire ext_hold = ~busy_s_r[1] & ~busy_in_disable_r;
  dac_gain_offset #(
    .W(W)
  ) u_calc (
    .clk(core_clk),
    .rst(irst),
    .start(calc_start),
    .code(input_r),
    .gain(gain_r),
    .offset(offset_r),
    .result_r(calc_result),
    .done_r(calc_done)
  );
  // a write landing mid-calculation is remembered and rerun
  always @(posedge core_clk) begin
    if (irst)
      pending_r <= 1'b0;
    else if (calc_req_r & ~calc_start)
      pending_r <= 1'b1;
    else if (calc_start)
      pending_r <= 1'b0;
  end
  // update sequencer
  always @* begin
    upd_state_nxt = upd_state_r;
    case (upd_state_r)
      UPD_IDLE: begin
        if (calc_start)
          upd_state_nxt = UPD_CALC;
      end
      UPD_CALC: begin
        if (calc_done)
          upd_state_nxt = ext_hold ? UPD_WAIT : UPD_IDLE;
      end
      UPD_WAIT: begin
        if (~ext_hold)
          upd_state_nxt = UPD_IDLE;
      end
      default: begin
        upd_state_nxt = UPD_IDLE;
      end
    endcase
  end
  always @(posedge core_clk) begin
    if (irst)
      upd_state_r <= UPD_IDLE;
    else
      upd_state_r <= upd_state_nxt;
  end
  // output code loads when the update leaves calc or wait
  wire upd_go = (upd_state_r != UPD_IDLE) & (upd_state_nxt == UPD_IDLE);
  always @(posedge core_clk) begin
    if (irst) begin
      dac_code_r <= `CODE_MIN;
      dac_update_r <= 1'b0;
    end else begin
      dac_update_r <= upd_go;
      if (upd_go)
        dac_code_r <= calc_result;
    end
  end
  // busy status: zero while calculating, one when idle
  wire busy_stat = (upd_state_r == UPD_IDLE) & ~pending_r & ~calc_req_r;
  // open-drain busy: pulled low while calculating
  assign busy_out = 1'b0;
  assign busy_oe = (upd_state_r == UPD_CALC) | calc_req_r;
  // ==========================================================
  // power-down: software bit or synchronised pin
  assign out_to_ground = soft_power_down_r | pd_s_r[1];
  // ==========================================================
  // readback word built at the end of a read frame
  wire [W-1:0] cfg_word = {soft_power_down_r, out_hold_disable_r, soft_reset_n_r,
    busy_in_disable_r, dout_on_r, busy_stat, 6'h00, REV_ID, 2'h0};
  always @(posedge core_clk) begin
    if (irst) begin
      tx_load_r <= 24'h000000;
      tx_load_v_r <= 1'b0;
    end else begin
      tx_load_v_r <= 1'b0;
      if (frame_end) begin
        tx_load_v_r <= 1'b1;
        if (cmd == `CMD_INPUT_RD)
          tx_load_r <= {cmd, input_r, 2'h0};
        else if (cmd == `CMD_OFFSET_RD)
          tx_load_r <= {cmd, offset_r, 2'h0};
        else if (cmd == `CMD_GAIN_RD)
          tx_load_r <= {cmd, gain_r, 2'h0};
        else if (cmd == `CMD_CONFIG_RD)
          tx_load_r <= {cmd, cfg_word, 2'h0};
        else
          tx_load_v_r <= 1'b0;
      end
    end
  end
  // ==========================================================
  // transmit shifter: read word out in the next frame, else echo
  reg dout_hold_r;
  always @(posedge core_clk) begin
    if (irst) begin
      tx_r <= 24'h000000;
      spi_dout_r <= 1'b0;
      dout_hold_r <= 1'b0;
    end else begin
      if (tx_load_v_r)
        tx_r <= tx_load_r;
      else if (sclk_rise & ~tx_load_v_r)
        tx_r <= {tx_r[22:0], din_q};
      if (cs_fall) begin
        dout_hold_r <= 1'b0;
        spi_dout_r <= dout_on_r & tx_r[23];
      end else if (sclk_fall) begin
        spi_dout_r <= dout_on_r & tx_r[23];
      end
      if (cs_rise)
        dout_hold_r <= 1'b1;
    end
  end
  // driven during the frame, held or released after it
  assign spi_dout_oe = ~cs_q | ~out_hold_disable_r;
endmodule // dac_calibration_config_regs

// [rtl/dac_gain_offset.v]
// Purpose: applies gain then offset to an input code
// Assumes: input code straight binary, offset two's complement
// Notes: two-cycle pipeline, result saturates to the code range
`include "dac_cal_regs.vh"
module dac_gain_offset #(
  parameter W = `DATA_W
) (
  input wire clk,
  input wire rst,
  input wire start,
  input wire [W-1:0] code,
  input wire [W-1:0] gain,
  input wire [W-1:0] offset,
  output reg [W-1:0] result_r,
  output reg done_r
);
  // ==========================================================
  // stage one: scaled code
  reg [2*W:0] prod_r;
  reg [W-1:0] offs_r;
  reg stage_r;
  wire [W:0] gain_p1 = {1'b0, gain} + {{W{1'b0}}, 1'b1};
  wire [W+1:0] sum = {2'b00, prod_r[2*W-1:W]} + {{2{offs_r[W-1]}}, offs_r};
  // gain of (gain+1)/2^18 applied first
  always @(posedge clk) begin
    if (rst) begin
      prod_r <= {(2*W+1){1'b0}};
      offs_r <= {W{1'b0}};
      stage_r <= 1'b0;
    end else begin
      stage_r <= start;
      if (start) begin
        prod_r <= {{(W+1){1'b0}}, code} * {{W{1'b0}}, gain_p1};
        offs_r <= offset;
      end
    end
  end
  // ==========================================================
  // stage two: offset add and clamp
  always @(posedge clk) begin
    if (rst) begin
      result_r <= {W{1'b0}};
      done_r <= 1'b0;
    end else begin
      done_r <= stage_r;
      if (stage_r) begin
        if (sum[W+1])
          result_r <= `CODE_MIN;
        else if (sum[W])
          result_r <= `CODE_MAX;
        else
          result_r <= sum[W-1:0];
      end
    end
  end
endmodule // dac_gain_offset

// [testbench/dac_cal_regs_assertions.sv]
// Purpose: port-level checks for the calibration register block
// Assumes: sees only the ports of the block
// Notes: bound into every instance of the block
module dac_cal_regs_checker #(
  parameter W = 18
) (
  input wire core_clk,
  input wire rst,
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_dout_r,
  input wire spi_dout_oe,
  input wire busy_out,
  input wire busy_oe,
  input wire power_down_pin,
  input wire out_to_ground,
  input wire [W-1:0] dac_code_r,
  input wire dac_update_r
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // ==========
  // sequences
  sequence s_pd_held;
    power_down_pin [*3];
  endsequence
  sequence s_link_quiet;
    ($stable(spi_sclk) && $stable(spi_cs_n)) [*8];
  endsequence
  sequence s_no_update;
    !dac_update_r [*3];
  endsequence
  // ==========
  // properties
  property p_pd_pin;
    s_pd_held |-> out_to_ground;
  endproperty
  a_pd_pin: assert property (p_pd_pin) else $error("pin power-down not applied");
  property p_oe_frame;
    (!spi_cs_n) [*4] |-> spi_dout_oe;
  endproperty
  a_oe_frame: assert property (p_oe_frame) else $error("data out not driven in frame");
  property p_dout_quiet;
    s_link_quiet |=> $stable(spi_dout_r);
  endproperty
  a_dout_quiet: assert property (p_dout_quiet) else $error("data out moved on idle link");
  property p_upd_pulse;
    dac_update_r |=> !dac_update_r;
  endproperty
  a_upd_pulse: assert property (p_upd_pulse) else $error("update longer than a cycle");
  property p_upd_idle_link;
    dac_update_r |-> spi_cs_n;
  endproperty
  a_upd_idle_link: assert property (p_upd_idle_link) else $error("update inside frame");
  property p_busy_low_only;
    !busy_out;
  endproperty
  a_busy_low_only: assert property (p_busy_low_only) else $error("busy pin driven high");
  property p_busy_calc;
    $rose(busy_oe) |-> s_no_update;
  endproperty
  a_busy_calc: assert property (p_busy_calc) else $error("update before calc time");
  property p_code_change;
    $changed(dac_code_r) |-> dac_update_r || dac_code_r == 18'h00000;
  endproperty
  a_code_change: assert property (p_code_change) else $error("code moved without update");
endmodule // dac_cal_regs_checker
bind dac_calibration_config_regs dac_cal_regs_checker #(.W(W)) u_chk (.core_clk(core_clk),
  .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_dout_r(spi_dout_r),
  .spi_dout_oe(spi_dout_oe), .busy_out(busy_out), .busy_oe(busy_oe),
  .power_down_pin(power_down_pin), .out_to_ground(out_to_ground),
  .dac_code_r(dac_code_r), .dac_update_r(dac_update_r));

// [testbench/dac_calibration_config_regs_tb_top.sv]
// Purpose: self-checking bench for the calibration register block
// Assumes: host model drives frames, busy pin has a pull-up
// Notes: lfsr stimulus with corner values
module dac_calibration_config_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] REV = 4'h1; // arbitrary revision value
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic power_down_pin = 1'b0;
  logic ext_hold = 1'b0;
  logic spi_sclk, spi_cs_n, spi_din, spi_dout_r, spi_dout_oe;
  logic busy_out, busy_oe, out_to_ground, dac_update_r;
  logic [17:0] dac_code_r, gm, om, cm;
  logic [17:0] oc [3] = '{18'h20000, 18'h3ffff, 18'h1ffff};
  logic [23:0] rx;
  logic [31:0] lfsr = 32'h002e3157;
  int err_total = 0;
  int n_checks = 0;
  int k;
  wire busy_in = !((busy_oe === 1'b1) || ext_hold); // open-drain wire level
  always #2.5 core_clk = ~core_clk;
  dac_calibration_config_regs #(.W(18), .REV_ID(REV)) dut (.core_clk(core_clk), .rst(rst),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_din(spi_din), .spi_dout_r(spi_dout_r),
    .spi_dout_oe(spi_dout_oe), .busy_in(busy_in), .busy_out(busy_out), .busy_oe(busy_oe),
    .power_down_pin(power_down_pin), .out_to_ground(out_to_ground),
    .dac_code_r(dac_code_r), .dac_update_r(dac_update_r));
  spi_host_model host (.sclk(spi_sclk), .cs_n(spi_cs_n), .din(spi_din),
    .dout(spi_dout_oe ? spi_dout_r : 1'bz));
  // ==========
  // expectations
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [17:0] calc(input logic [17:0] c, g, o);
    longint p;
    p = ((longint'(c) * (longint'(g) + 1)) >>> 18) + longint'($signed(o));
    return (p < 0) ? 18'h00000 : (p > 262143) ? 18'h3ffff : 18'(p);
  endfunction
  function automatic logic [17:0] cfgw(input logic [4:0] f);
    return {f, 1'b1, 6'h00, REV, 2'b00};
  endfunction
  // ==========
  // shared tasks
  task automatic chk(input logic [23:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic upd(input int lim);
    k = 0;
    while (dac_update_r !== 1'b1 && k < lim) begin
      cyc(1);
      k++;
    end
  endtask
  task automatic rd(input logic [3:0] c, input logic [17:0] e);
    lfsr = step(lfsr);
    host.frame(c, lfsr[17:0], rx);
    host.frame(4'h0, 18'h00000, rx);
    chk(rx, {c, e, 2'b00}, "read");
  endtask
  task automatic wr(input logic [3:0] c, input logic [17:0] d);
    host.frame(c, d, rx);
    case (c)
      4'h1: cm = d;
      4'h2: om = d;
      default: gm = d;
    endcase
    upd(12);
    chk(24'(k < 12), 24'h1, "update seen");
    chk({6'h00, dac_code_r}, {6'h00, calc(cm, gm, om)}, "code");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========
  // main sequence
  initial begin
    gm = 18'h3ffff;
    om = 18'h00000;
    cm = 18'h00000;
    cyc(16);
    rst = 1'b0;
    host.frame(4'hb, 18'h00000, rx);
    host.frame(4'h4, 18'h0a5a5, rx);
    chk(rx, 24'h000000, "dout off");
    rd(4'hc, cfgw(5'h05));
    rd(4'hb, 18'h3ffff);
    rd(4'ha, 18'h00000);
    rd(4'h9, 18'h00000);
    for (int i = 0; i < 8; i++) begin
      lfsr = step(lfsr);
      wr(4'h2, (i < 3) ? oc[i] : lfsr[17:0]);
      lfsr = step(lfsr);
      wr(4'h3, (i == 0) ? 18'h00000 : lfsr[17:0]);
      lfsr = step(lfsr);
      wr(4'h1, lfsr[17:0]);
      rd(4'ha, om);
      rd(4'hb, gm);
      rd(4'h9, cm);
    end
    // outside hold defers the update
    cyc(1);
    ext_hold = 1'b1;
    cm = lfsr[17:0] ^ 18'h15555;
    host.frame(4'h1, cm, rx);
    upd(40);
    chk(24'(k), 24'h000028, "deferred");
    ext_hold = 1'b0;
    upd(10);
    chk({6'h00, dac_code_r}, {6'h00, calc(cm, gm, om)}, "released");
    // busy input disabled
    host.frame(4'h4, 18'h0e123, rx);
    cyc(1);
    ext_hold = 1'b1;
    wr(4'h1, lfsr[17:0] ^ 18'h2aaaa);
    ext_hold = 1'b0;
    rd(4'hc, cfgw(5'h07));
    // data out release, power-down
    host.frame(4'h4, 18'h3a000, rx);
    cyc(8);
    chk(24'(spi_dout_oe), 24'h0, "released dout");
    chk(24'(out_to_ground), 24'h1, "soft pd");
    host.frame(4'h4, 18'h0a000, rx);
    cyc(8);
    chk(24'(spi_dout_oe), 24'h1, "held dout");
    chk(24'(out_to_ground), 24'h0, "pd off");
    power_down_pin = 1'b1;
    cyc(5);
    chk(24'(out_to_ground), 24'h1, "pin pd");
    power_down_pin = 1'b0;
    // software reset
    wr(4'h3, 18'h12345);
    host.frame(4'h4, 18'h00000, rx);
    gm = 18'h3ffff;
    cyc(8);
    chk({6'h00, dac_code_r}, 24'h000000, "soft reset code");
    chk(24'(spi_dout_oe), 24'h1, "default hold");
    host.frame(4'h4, 18'h0a000, rx);
    rd(4'hb, gm);
    rd(4'h9, 18'h00000);
    print_verdict();
  end
  // ==========
  // watchdog
  initial begin
    #400us;
    err_total++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    print_verdict();
  end
endmodule // dac_calibration_config_regs_tb_top

// [testbench/spi_host_model.sv]
// Purpose: host side of the serial link, 24-clock frames
// Assumes: clock idles low, device moves data out on falling edges
// Notes: reply captured on rising edges; din inverted between frames
module spi_host_model (
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // ==========
  // one frame after an idle gap, 64 ns clock
  task automatic frame(input logic [3:0] c, input logic [17:0] d, output logic [23:0] rx);
    logic [23:0] w;
    w = {c, d, 2'b00};
    #100 cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      din = w[i];
      #32 sclk = 1'b1;
      rx[i] = dout;
      #32 sclk = 1'b0;
    end
    #32 cs_n = 1'b1;
    din = ~din; // line no longer meaningful
  endtask
endmodule // spi_host_model
